/* File: data_signal_modulator.sv */
// Data signal modulator: register file on AXI4-Lite and the carrier mixer.
// Assumes all sources arrive asynchronously and pass a two-stage synchroniser.
`include "modulator_params.svh"
module data_signal_modulator (
  input  wire logic        aclk,              // System clock, 25 MHz.
  input  wire logic        aresetn,           // Synchronous reset, active low.
  input  wire logic [7:0]  awaddr,            // Write address.
  input  wire logic        awvalid,           // Write address valid.
  output logic             awready,           // Write address ready.
  input  wire logic [31:0] wdata,             // Write data.
  input  wire logic [3:0]  wstrb,             // Write byte strobes.
  input  wire logic        wvalid,            // Write data valid.
  output logic             wready,            // Write data ready.
  output logic [1:0]       bresp,             // Write response.
  output logic             bvalid,            // Write response valid.
  input  wire logic        bready,            // Write response ready.
  input  wire logic [7:0]  araddr,            // Read address.
  input  wire logic        arvalid,           // Read address valid.
  output logic             arready,           // Read address ready.
  output logic [31:0]      rdata,             // Read data.
  output logic [1:0]       rresp,             // Read response.
  output logic             rvalid,            // Read data valid.
  input  wire logic        rready,            // Read data ready.
  input  wire logic [7:0]  carrier_sources,   // Carrier sources 1..7 in bits 1..7; bit 0 unused.
  input  wire logic        high_carrier_pin,  // Routed high carrier pin.
  input  wire logic        low_carrier_pin,   // Routed low carrier pin.
  input  wire logic [15:0] modulating_sources,// Modulating sources by code; bits 0,1,14,15 unused.
  input  wire logic        modulating_pin,    // Routed modulating pin.
  output logic             modulated_out      // Modulated output pin.
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  mod_control;
    logic [7:0]  carrier_option;
    logic [7:0]  high_sel;
    logic [7:0]  low_sel;
    logic [7:0]  mod_sel;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    modulator_pkg::carrier_state_type cstate;
    logic        high_prev;
    logic        low_prev;
    logic        out;
  } dsm_state_type;
  dsm_state_type st_r;
  dsm_state_type st_nxt;

  // Synchronised external sources.
  logic [7:0]  carrier_s;
  logic        high_pin_s;
  logic        low_pin_s;
  logic [15:0] mod_s;
  logic        mod_pin_s;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  sync2 #(.W(27)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({carrier_sources, high_carrier_pin, low_carrier_pin, modulating_sources, modulating_pin}),
    .sync_out ({carrier_s, high_pin_s, low_pin_s, mod_s, mod_pin_s})
  );

  // Picks a carrier; code zero is the side's own routed pin.
  function automatic logic pick_carrier(input logic [2:0] code, input logic pin, input logic [7:0] srcs);
    logic v;
    v = srcs[code];
    if (code == 3'h0) begin
      v = pin;
    end
    return v;
  endfunction

  // Reads one register with unimplemented bits forced to zero.
  function automatic logic [7:0] reg_read(input logic [7:0] addr, input dsm_state_type s, output logic hit);
    logic [7:0] v;
    v   = 8'h00;
    hit = 1'b1;
    unique case (addr)
      `MOD_CONTROL_ADDR: begin
        v = s.mod_control & `MOD_CONTROL_MASK;
        v[`OUT_STATUS_BIT] = s.out;
      end
      `CARRIER_OPTION_ADDR:   v = s.carrier_option;
      `HIGH_CARRIER_SEL_ADDR: v = s.high_sel;
      `LOW_CARRIER_SEL_ADDR:  v = s.low_sel;
      `MODULATING_SEL_ADDR:   v = s.mod_sel;
      default:                hit = 1'b0;
    endcase
    return v;
  endfunction

  // Mixer signals.
  logic enable;
  logic high_c;
  logic low_c;
  logic mod_sig;
  logic use_high;
  logic mixed;

  // ----------------------------------------
  // Source selection and mixing
  // ----------------------------------------
  // Disabled: carriers default to the pins and the source to the soft bit, saving toggling.
  always_comb begin
    enable = st_r.mod_control[`ENABLE_BIT];
    high_c = pick_carrier(enable ? st_r.high_sel[2:0] : 3'h0, high_pin_s, carrier_s)
             ^ st_r.carrier_option[`HIGH_INVERT_BIT];
    low_c  = pick_carrier(enable ? st_r.low_sel[2:0] : 3'h0, low_pin_s, carrier_s)
             ^ st_r.carrier_option[`LOW_INVERT_BIT];
    mod_sig = st_r.mod_control[`SOFT_BIT];
    if (enable) begin
      unique case (st_r.mod_sel[3:0])
        `SRC_PIN:  mod_sig = mod_pin_s;
        `SRC_SOFT: mod_sig = st_r.mod_control[`SOFT_BIT];
        4'he, 4'hf: mod_sig = 1'b0;
        default:   mod_sig = mod_s[st_r.mod_sel[3:0]];
      endcase
    end
    use_high = (st_r.cstate == modulator_pkg::SEL_HIGH) || (st_r.cstate == modulator_pkg::WAIT_HIGH_FALL);
    // Output is the chosen carrier ANDed with the modulating signal, except that a synced
    // high carrier keeps the pulse it is in; otherwise the sync wait would still truncate it.
    mixed = enable & (use_high ? (high_c & (mod_sig | st_r.carrier_option[`HIGH_SYNC_BIT]))
                               : (low_c & mod_sig));
  end

  // ----------------------------------------
  // Bus and carrier state machine
  // ----------------------------------------
  always_comb begin
    logic       hit;
    logic [7:0] rv;
    logic       high_fall;
    logic       low_fall;
    hit = 1'b0;
    rv  = 8'h00;
    high_fall = st_r.high_prev & ~high_c;
    low_fall  = st_r.low_prev & ~low_c;
    st_nxt = st_r;
    st_nxt.high_prev = high_c;
    st_nxt.low_prev  = low_c;

    // Write address and data are taken independently, in either order.
    if (awvalid && !st_r.aw_held) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = awaddr;
    end
    if (wvalid && !st_r.w_held) begin
      st_nxt.w_held  = 1'b1;
      st_nxt.w_data  = wdata[7:0];
      st_nxt.w_lane0 = wstrb[0];
    end
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = 2'b00;
      // Masks keep unimplemented bits at zero.
      unique case (st_r.aw_addr)
        `MOD_CONTROL_ADDR:      if (st_r.w_lane0) st_nxt.mod_control    = st_r.w_data & `MOD_CONTROL_MASK;
        `CARRIER_OPTION_ADDR:   if (st_r.w_lane0) st_nxt.carrier_option = st_r.w_data & `CARRIER_OPTION_MASK;
        `HIGH_CARRIER_SEL_ADDR: if (st_r.w_lane0) st_nxt.high_sel       = st_r.w_data & `CARRIER_SEL_MASK;
        `LOW_CARRIER_SEL_ADDR:  if (st_r.w_lane0) st_nxt.low_sel        = st_r.w_data & `CARRIER_SEL_MASK;
        `MODULATING_SEL_ADDR:   if (st_r.w_lane0) st_nxt.mod_sel        = st_r.w_data & `MODULATING_SEL_MASK;
        default:                st_nxt.bresp = 2'b10;
      endcase
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken.
    if (arvalid && !st_r.rvalid) begin
      rv = reg_read(araddr, st_r, hit);
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = {24'h000000, rv};
      st_nxt.rresp  = hit ? 2'b00 : 2'b10;
    end else if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Carrier switch: immediate unless the outgoing carrier's sync bit asks for its falling edge.
    unique case (st_r.cstate)
      modulator_pkg::SEL_HIGH: begin
        if (!mod_sig) begin
          if (st_r.carrier_option[`HIGH_SYNC_BIT] && high_c) begin
            st_nxt.cstate = modulator_pkg::WAIT_HIGH_FALL;
          end else begin
            st_nxt.cstate = modulator_pkg::SEL_LOW;
          end
        end
      end
      modulator_pkg::WAIT_HIGH_FALL: begin
        if (mod_sig) begin
          st_nxt.cstate = modulator_pkg::SEL_HIGH;
        end else if (high_fall || !st_r.carrier_option[`HIGH_SYNC_BIT]) begin
          st_nxt.cstate = modulator_pkg::SEL_LOW;
        end
      end
      modulator_pkg::SEL_LOW: begin
        if (mod_sig) begin
          if (st_r.carrier_option[`LOW_SYNC_BIT] && low_c) begin
            st_nxt.cstate = modulator_pkg::WAIT_LOW_FALL;
          end else begin
            st_nxt.cstate = modulator_pkg::SEL_HIGH;
          end
        end
      end
      modulator_pkg::WAIT_LOW_FALL: begin
        if (!mod_sig) begin
          st_nxt.cstate = modulator_pkg::SEL_LOW;
        end else if (low_fall || !st_r.carrier_option[`LOW_SYNC_BIT]) begin
          st_nxt.cstate = modulator_pkg::SEL_HIGH;
        end
      end
    endcase

    // Output register; disabled forces a low pin after polarity, overriding the output invert bit.
    st_nxt.out = mixed ^ st_r.mod_control[`OUTPUT_INVERT_BIT];
    if (!enable) begin
      st_nxt.out = 1'b0;
    end
  end

  // All state clears on reset, except cstate, which loads SEL_LOW.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.cstate <= modulator_pkg::SEL_LOW;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign awready = !st_r.aw_held;
  assign wready  = !st_r.w_held;
  assign bvalid  = st_r.bvalid;
  assign bresp   = st_r.bresp;
  assign arready = !st_r.rvalid;
  assign rvalid  = st_r.rvalid;
  assign rdata   = st_r.rdata;
  assign rresp   = st_r.rresp;
  assign modulated_out = st_r.out;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_disabled_low: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(enable) |-> !modulated_out) else $error("output not low while disabled");
  a_status_tracks: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && araddr == `MOD_CONTROL_ADDR) |=> rdata[`OUT_STATUS_BIT] == $past(modulated_out))
    else $error("status bit does not show output");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid |-> rdata[31:8] == 24'h000000) else $error("upper read bits not zero");
  a_ctrl_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.mod_control & ~`MOD_CONTROL_MASK) == 8'h00) else $error("unimplemented control bit set");
  a_and_mix: assert property (@(posedge aclk) disable iff (!aresetn)
    (enable && !mod_sig && !st_r.mod_control[`OUTPUT_INVERT_BIT]
     && !(use_high && st_r.carrier_option[`HIGH_SYNC_BIT])) |=> !modulated_out)
    else $error("output high with low modulating signal");
  a_invert_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (enable && !mod_sig && st_r.mod_control[`OUTPUT_INVERT_BIT]
     && !(use_high && st_r.carrier_option[`HIGH_SYNC_BIT])) |=> modulated_out)
    else $error("inverted output not idle high");
  a_nosync_switch: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.cstate == modulator_pkg::SEL_HIGH && !mod_sig && !st_r.carrier_option[`HIGH_SYNC_BIT])
    |=> st_r.cstate == modulator_pkg::SEL_LOW) else $error("unsynced switch delayed");
  a_sync_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.cstate == modulator_pkg::WAIT_HIGH_FALL && !mod_sig && high_c && st_r.carrier_option[`HIGH_SYNC_BIT])
    |=> st_r.cstate != modulator_pkg::SEL_LOW)
    else $error("switched before high carrier fell");
  // Sync waits: the outgoing carrier's pulse is kept, and the switch waits for its fall.
  sequence s_high_pulse;
    enable && st_r.cstate == modulator_pkg::WAIT_HIGH_FALL && high_c && st_r.carrier_option[`HIGH_SYNC_BIT];
  endsequence
  sequence s_low_wait;
    st_r.cstate == modulator_pkg::WAIT_LOW_FALL && mod_sig && low_c && st_r.carrier_option[`LOW_SYNC_BIT];
  endsequence
  a_high_pulse_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    s_high_pulse |=> modulated_out != st_r.mod_control[`OUTPUT_INVERT_BIT])
    else $error("high carrier pulse cut during sync wait");
  a_low_sync_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_low_wait |=> st_r.cstate != modulator_pkg::SEL_HIGH) else $error("switched before low carrier fell");
  a_reset_zero: assert property (@(posedge aclk)
    !aresetn |=> (st_r.mod_control == 8'h00 && st_r.mod_sel == 8'h00)) else $error("registers not cleared");
endmodule

/* File: modulator_params.svh */
// Register offsets, field positions, reset values and mux codes of the modulator.
// Assumes inclusion by the main module and the bench only.
`ifndef MODULATOR_PARAMS_SVH
`define MODULATOR_PARAMS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define MOD_CONTROL_ADDR       8'h00
`define CARRIER_OPTION_ADDR    8'h04
`define HIGH_CARRIER_SEL_ADDR  8'h08
`define LOW_CARRIER_SEL_ADDR   8'h0c
`define MODULATING_SEL_ADDR    8'h10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ENABLE_BIT             7
`define OUT_STATUS_BIT         5
`define OUTPUT_INVERT_BIT      4
`define SOFT_BIT               0
`define HIGH_INVERT_BIT        5
`define HIGH_SYNC_BIT          4
`define LOW_INVERT_BIT         1
`define LOW_SYNC_BIT           0
// ----------------------------------------
// Writable masks and reset value
// ----------------------------------------
`define MOD_CONTROL_MASK       8'h91
`define CARRIER_OPTION_MASK    8'h33
`define CARRIER_SEL_MASK       8'h07
`define MODULATING_SEL_MASK    8'h0f
`define REG_RESET              8'h00
// ----------------------------------------
// Modulating source codes
// ----------------------------------------
`define SRC_PIN                4'h0
`define SRC_SOFT               4'h1
`endif

/* File: modulator_pkg.sv */
// Types shared by the modulator design.
// Assumes modulator_params.svh for numeric constants.
package modulator_pkg;
  typedef enum logic [1:0] {SEL_HIGH, SEL_LOW, WAIT_HIGH_FALL, WAIT_LOW_FALL} carrier_state_type;
endpackage

/* File: sig_sources.sv */
// Model of the on-chip signal sources and pins that feed the modulator.
// Assumes the bench sets which codes are in use and their levels.
module sig_sources (
  input  wire logic [2:0] h_code,              // High carrier code in use.
  input  wire logic       h_lvl,               // Level of the high carrier.
  input  wire logic [2:0] l_code,              // Low carrier code in use.
  input  wire logic       l_lvl,               // Level of the low carrier.
  input  wire logic [3:0] m_code,              // Modulating code in use.
  input  wire logic       m_lvl,               // Level of the modulating source.
  output logic      [7:0] carrier_sources,     // Carrier codes 1 to 7.
  output logic            high_carrier_pin,    // High carrier code zero pin.
  output logic            low_carrier_pin,     // Low carrier code zero pin.
  output logic     [15:0] modulating_sources,  // Modulating codes 2 to 13.
  output logic            modulating_pin       // Modulating code zero pin.
);
  timeunit 1ns;
  timeprecision 1ns;
  // -----------------------------------------
  // Source levels
  // -----------------------------------------
  // Unused sources show the inverse level (unused carrier codes the inverse of h_lvl), so a wrong mux choice shows at the output.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      carrier_sources[i] = (i == int'(h_code)) ? h_lvl : (i == int'(l_code)) ? l_lvl : ~h_lvl;
    end
    for (int i = 0; i < 16; i++) begin
      modulating_sources[i] = (i == int'(m_code)) ? m_lvl : ~m_lvl;
    end
    high_carrier_pin = (h_code == 3'h0) ? h_lvl : ~h_lvl;
    low_carrier_pin  = (l_code == 3'h0) ? l_lvl : ~l_lvl;
    modulating_pin   = (m_code == 4'h0) ? m_lvl : ~m_lvl;
  end
endmodule

/* File: sync2.sv */
// Two flip-flop synchroniser for a bus of asynchronous inputs.
// Assumes the inputs are unrelated to aclk.
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         aclk,      // System clock.
  input  wire logic         aresetn,   // Synchronous reset, active low.
  input  wire logic [W-1:0] async_in,  // Asynchronous inputs.
  output logic      [W-1:0] sync_out   // Synchronised copies.
);
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } sync_state_type;
  sync_state_type st_r;
  sync_state_type st_nxt;

  // The first stage feeds only the second stage.
  always_comb begin
    st_nxt.first  = async_in;
    st_nxt.second = st_r.first;
  end

  // Both stages clear on reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.second;
endmodule

/* File: tb_top.sv */
// Self-checking bench for the data signal modulator.
// Assumes the design answers on AXI4-Lite and the source model drives all mux inputs.
`include "modulator_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [3:0] ws;
  logic [7:0] awaddr, araddr, cs;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, m_code;
  logic [1:0] bresp, rresp;
  logic [2:0] h_code, l_code;
  logic h_lvl, l_lvl, m_lvl, hp, lp, mp, modulated_out;
  logic [15:0] ms;
  int bad_count, checks;
  logic [7:0] ra [4] = '{`CARRIER_OPTION_ADDR, `HIGH_CARRIER_SEL_ADDR, `LOW_CARRIER_SEL_ADDR, `MODULATING_SEL_ADDR};
  logic [7:0] rm [4] = '{`CARRIER_OPTION_MASK, `CARRIER_SEL_MASK, `CARRIER_SEL_MASK, `MODULATING_SEL_MASK};

  data_signal_modulator uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .carrier_sources(cs),
    .high_carrier_pin(hp), .low_carrier_pin(lp), .modulating_sources(ms), .modulating_pin(mp),
    .modulated_out(modulated_out));
  sig_sources src (.h_code(h_code), .h_lvl(h_lvl), .l_code(l_code), .l_lvl(l_lvl), .m_code(m_code),
    .m_lvl(m_lvl), .carrier_sources(cs), .high_carrier_pin(hp), .low_carrier_pin(lp),
    .modulating_sources(ms), .modulating_pin(mp));

  // -----------------------------------------
  // Clock and shared tasks
  // -----------------------------------------
  // Clock of 40 ns period.
  always #20 aclk = ~aclk;

  task automatic end_sim();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // A wait that runs out of cycles counts as a mismatch and closes the run.
  task automatic limit(input bit done);
    if (!done) begin
      bad_count++;
      $display("CHECK FAILED bus wait expected answer seen none");
      end_sim();
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    bit done;
    n = 0;
    done = 0;
    awaddr <= a; wdata <= {24'h0, d}; wstrb <= ws;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!done && n < 50) begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        chk("bresp", 32'(bresp), 32'(er));
        bready <= 1'b0;
        done = 1;
      end
    end
    // One idle edge keeps the next call's strobes out of this time step.
    @(posedge aclk);
    limit(done);
  endtask

  task automatic axr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    bit done;
    n = 0;
    done = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!done && n < 50) begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        chk("rresp", 32'(rresp), 32'(er));
        if (er == 2'b00) chk("rdata", rdata, {24'h0, d});
        rready <= 1'b0;
        done = 1;
      end
    end
    // One idle edge keeps the next call's strobes out of this time step.
    @(posedge aclk);
    limit(done);
  endtask

  // The source path takes about four cycles; eight leave margin.
  task automatic oc(input logic e);
    repeat (8) @(posedge aclk);
    chk("modulated_out", 32'(modulated_out), 32'(e));
  endtask

  // -----------------------------------------
  // Main sequence
  // -----------------------------------------
  initial begin
    aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; ws = 4'hf;
    h_code = 0; h_lvl = 1; l_code = 0; l_lvl = 0; m_code = 1; m_lvl = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`MOD_CONTROL_ADDR, `REG_RESET, 2'b00);
    for (int i = 0; i < 4; i++) begin
      axr(ra[i], `REG_RESET, 2'b00);
      axw(ra[i], 8'hff, 2'b00);
      axr(ra[i], rm[i], 2'b00);
      axw(ra[i], 8'h00, 2'b00);
    end
    axw(`MOD_CONTROL_ADDR, 8'h6e, 2'b00);
    axr(`MOD_CONTROL_ADDR, 8'h00, 2'b00);
    axw(8'h14, 8'hff, 2'b10);
    axr(8'h14, 8'h00, 2'b10);
    // A write without byte lane zero leaves the register at its reset value.
    ws = 4'he;
    axw(`HIGH_CARRIER_SEL_ADDR, 8'h05, 2'b00);
    ws = 4'hf;
    axr(`HIGH_CARRIER_SEL_ADDR, `REG_RESET, 2'b00);
    // Disabled with output invert and soft bit set must still hold the pin low.
    axw(`MOD_CONTROL_ADDR, 8'h11, 2'b00);
    oc(1'b0);
    axw(`MODULATING_SEL_ADDR, 8'h01, 2'b00);
    axw(`MOD_CONTROL_ADDR, 8'h81, 2'b00);
    oc(1'b1);
    axr(`MOD_CONTROL_ADDR, 8'ha1, 2'b00);
    axw(`MOD_CONTROL_ADDR, 8'h91, 2'b00);
    oc(1'b0);
    axw(`MOD_CONTROL_ADDR, 8'h90, 2'b00);
    oc(1'b1);
    axw(`MOD_CONTROL_ADDR, 8'h81, 2'b00);
    // Every high carrier code, both levels; the low carrier stays on its pin.
    for (int i = 0; i < 8; i++) begin
      axw(`HIGH_CARRIER_SEL_ADDR, 8'(i), 2'b00);
      h_code <= 3'(i);
      for (int v = 0; v < 2; v++) begin
        h_lvl <= 1'(v);
        oc(1'(v));
      end
    end
    axw(`HIGH_CARRIER_SEL_ADDR, 8'h00, 2'b00);
    h_code <= 3'h0;
    axw(`CARRIER_OPTION_ADDR, 8'h20, 2'b00);
    h_lvl <= 1'b0;
    oc(1'b1);
    axw(`CARRIER_OPTION_ADDR, 8'h00, 2'b00);
    h_lvl <= 1'b1;
    // Every modulating code; the soft bit is set but counts only under code one.
    for (int c = 0; c < 16; c++) begin
      axw(`MODULATING_SEL_ADDR, 8'(c), 2'b00);
      m_code <= 4'(c);
      for (int v = 0; v < 2; v++) begin
        m_lvl <= 1'(v);
        oc((c == 1) ? 1'b1 : (c < 14) ? 1'(v) : 1'b0);
      end
    end
    axw(`MODULATING_SEL_ADDR, 8'h01, 2'b00);
    // Without sync the switch is immediate; with sync it waits for the high carrier to fall.
    axw(`MOD_CONTROL_ADDR, 8'h80, 2'b00);
    oc(1'b0);
    axw(`MOD_CONTROL_ADDR, 8'h81, 2'b00);
    axw(`CARRIER_OPTION_ADDR, 8'h10, 2'b00);
    oc(1'b1);
    axw(`MOD_CONTROL_ADDR, 8'h80, 2'b00);
    oc(1'b1);
    h_lvl <= 1'b0;
    oc(1'b0);
    h_lvl <= 1'b1;
    oc(1'b0);
    // Low carrier on a mux code, inverted and synced: its pulse outlives the switch to high.
    h_lvl <= 1'b0;
    l_code <= 3'h3;
    axw(`LOW_CARRIER_SEL_ADDR, 8'h03, 2'b00);
    axw(`CARRIER_OPTION_ADDR, 8'h03, 2'b00);
    axw(`MOD_CONTROL_ADDR, 8'h81, 2'b00);
    oc(1'b1);
    l_lvl <= 1'b1;
    oc(1'b0);
    l_lvl <= 1'b0;
    oc(1'b0);
    // A second reset in mid-run clears the control bits again.
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`MOD_CONTROL_ADDR, `REG_RESET, 2'b00);
    axr(`CARRIER_OPTION_ADDR, `REG_RESET, 2'b00);
    end_sim();
  end
endmodule
